// [core_model.sv]
// Core model: issues one data-space store per request
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from bench
  input wire logic go_i,
  input wire logic short_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic stall_i,
  // Store port
  output logic st_valid_o,
  output logic st_short_o,
  output logic [15:0] st_addr_o,
  output logic [7:0] st_data_o
);
  // Address and data lines invert when idle so a stale value never passes for a store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_valid_o <= 1'b0;
      st_short_o <= 1'b0;
      st_addr_o <= 16'h0000;
      st_data_o <= 8'h00;
    end else if (go_i && !stall_i) begin
      st_valid_o <= 1'b1;
      st_short_o <= short_i;
      st_addr_o <= addr_i;
      st_data_o <= data_i;
    end else begin
      st_valid_o <= 1'b0;
      st_addr_o <= ~st_addr_o;
      st_data_o <= ~st_data_o;
    end
  end
endmodule : core_model
`default_nettype wire

// [flash_program_erase_lock.sv]
// Flash program/erase sequencer with key lock and page security
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_lock
  import flash_seq_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core data-space store and load
  input wire logic st_valid_i,
  input wire logic st_short_i,
  input wire logic [15:0] st_addr_i,
  input wire logic [7:0] st_data_i,
  input wire logic ld_valid_i,
  input wire logic exec_locked_i,
  output logic ram_we_o,
  output logic ram_re_o,
  output logic stall_o,
  // Code-space read and debug port
  input wire logic code_rd_i,
  input wire logic dbg_i,
  input wire logic [ADDR_W-1:0] code_addr_i,
  output logic code_rd_ok_o,
  // Supply monitor
  input wire logic supmon_en_i,
  input wire logic supmon_rst_en_i,
  // Flash array port
  output logic fl_we_o,
  output logic fl_erase_o,
  output logic [ADDR_W-1:0] fl_addr_o,
  output logic [31:0] fl_data_o,
  output logic [3:0] fl_mask_o,
  input wire logic [7:0] lock_byte_i,
  // Reset request and cause
  output logic flash_err_rst_o,
  output logic flash_error_cause_flag
);
  logic store_write_enable, next_we;
  logic store_erase_enable, next_ee;
  logic block_write_enable, next_blk;
  logic [1:0] code_bank_field, next_bank;
  key_state_t key_q, next_key;
  op_state_t op_q, next_op;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [7:0] lock_q, next_lock;
  logic lock_cap, next_lock_cap;
  logic [31:0] cache, next_cache;
  logic [3:0] cmask, next_cmask;
  logic [ADDR_W-1:0] fa, next_fa;
  logic [31:0] fd, next_fd;
  logic [3:0] fm, next_fm;
  logic err, next_err;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;

  // Address decode and security view
  logic wb_req, key_wr;
  logic [ADDR_W-1:0] st_full;
  logic [PAGE_W-1:0] st_page, rd_page;
  logic [7:0] n_locked;
  logic st_locked, rd_locked, modify, page_prot;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack;
  assign key_wr = wb_req && wb_we_i && wb_adr_i == REG_KEY && wb_sel_i[0];
  assign st_full = {code_bank_field[0], st_addr_i};
  assign st_page = st_full[ADDR_W-1:PAGE_BITS];
  assign rd_page = code_addr_i[ADDR_W-1:PAGE_BITS];
  assign n_locked = ~lock_q;
  // Lock page holds the lock byte; locked when any page is locked
  function automatic logic prot(input logic [PAGE_W-1:0] pg);
    prot = ({1'b0, pg} < n_locked) ||
      (pg == LOCK_ADDR[ADDR_W-1:PAGE_BITS] && lock_q != LOCK_RESET);
  endfunction : prot
  assign st_locked = prot(st_page);
  assign rd_locked = prot(rd_page);
  assign page_prot = st_locked && !exec_locked_i;
  // Store goes to flash only with write enable and in range
  assign modify = st_valid_i && store_write_enable &&
    !(st_short_i && {1'b0, st_addr_i} > SHORT_MAX);
  assign ram_we_o = st_valid_i && !modify;
  assign ram_re_o = ld_valid_i;
  assign stall_o = op_q != OP_IDLE;
  assign code_rd_ok_o = code_rd_i && !(rd_locked && (dbg_i || !exec_locked_i));
  assign fl_we_o = op_q == OP_WRITE;
  assign fl_erase_o = op_q == OP_ERASE;
  assign fl_addr_o = fa;
  assign fl_data_o = fd;
  assign fl_mask_o = fm;
  assign flash_err_rst_o = err;
  assign flash_error_cause_flag = err;
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;

  // Next-state of control registers, key lock and operation
  always_comb begin
    next_we = store_write_enable;
    next_ee = store_erase_enable;
    next_blk = block_write_enable;
    next_bank = code_bank_field;
    next_key = key_q;
    next_op = op_q;
    next_cnt = cnt;
    next_lock = lock_q;
    next_lock_cap = 1'b1;
    next_cache = cache;
    next_cmask = cmask;
    next_fa = fa;
    next_fd = fd;
    next_fm = fm;
    next_err = 1'b0;
    next_ack = wb_req;
    next_rdat = 32'h0000_0000;
    // Lock byte is sampled once after reset only
    if (!lock_cap) begin
      next_lock = lock_byte_i;
    end
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: next_rdat = {29'h0, block_write_enable, store_erase_enable,
                               store_write_enable};
        REG_BANK: next_rdat = {30'h0, code_bank_field};
        REG_STATUS: next_rdat = {24'h0, lock_q};
        REG_KEY: next_rdat = {30'h0, key_q};
        default: next_rdat = 32'h0000_0000;
      endcase
    end
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        next_we = wb_dat_i[CTRL_WE];
        next_ee = wb_dat_i[CTRL_EE];
        next_blk = wb_dat_i[CTRL_BLK];
        if (!wb_dat_i[CTRL_BLK]) begin
          next_cmask = 4'h0;
        end
      end else if (wb_adr_i == REG_BANK) begin
        next_bank = wb_dat_i[1:0];
      end
    end
    // Key sequence
    if (key_wr && key_q != KEY_DEAD) begin
      case (key_q)
        KEY_LOCKED: next_key = (wb_dat_i[7:0] == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
        KEY_HALF: next_key = (wb_dat_i[7:0] == KEY_SECOND) ? KEY_OPEN : KEY_DEAD;
        default: next_key = KEY_DEAD;
      endcase
    end
    // Flash modification attempt
    if (modify && op_q == OP_IDLE) begin
      if (!supmon_en_i || !supmon_rst_en_i || page_prot) begin
        next_err = 1'b1;
      end else if (key_q != KEY_OPEN) begin
        next_key = KEY_DEAD;
      end else begin
        next_key = KEY_LOCKED;
        if (store_erase_enable) begin
          next_op = OP_ERASE;
          next_fa = {st_page, {PAGE_BITS{1'b0}}};
          next_fd = {4{ERASED}};
          next_fm = 4'hF;
          next_cnt = CNT_W'(ERASE_CYCLES - 1);
        end else if (block_write_enable) begin
          next_cache[st_full[1:0]*8 +: 8] = st_data_i;
          next_cmask[st_full[1:0]] = 1'b1;
          if (st_full[1:0] == 2'b11) begin
            next_op = OP_WRITE;
            next_fa = {st_full[ADDR_W-1:2], 2'b00};
            next_fd = next_cache;
            next_fm = next_cmask;
            next_cmask = 4'h0;
            next_cnt = CNT_W'(WRITE_CYCLES - 1);
          end
        end else begin
          next_op = OP_WRITE;
          next_fa = st_full;
          next_fd = {4{st_data_i}};
          next_fm = 4'h1 << st_full[1:0];
          next_cnt = CNT_W'(WRITE_CYCLES - 1);
        end
      end
    end
    // User code outside the locked area reading a locked page
    if (code_rd_i && rd_locked && !dbg_i && !exec_locked_i) begin
      next_err = 1'b1;
    end
    // Internal timing of the operation
    if (op_q != OP_IDLE) begin
      if (cnt == '0) begin
        next_op = OP_IDLE;
      end else begin
        next_cnt = cnt - 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_write_enable <= 1'b0;
      store_erase_enable <= 1'b0;
      block_write_enable <= 1'b0;
      code_bank_field <= 2'b00;
      key_q <= KEY_LOCKED;
      op_q <= OP_IDLE;
      cnt <= '0;
      lock_q <= LOCK_RESET;
      lock_cap <= 1'b0;
      cache <= 32'h0000_0000;
      cmask <= 4'h0;
      fa <= '0;
      fd <= 32'h0000_0000;
      fm <= 4'h0;
      err <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      store_write_enable <= next_we;
      store_erase_enable <= next_ee;
      block_write_enable <= next_blk;
      code_bank_field <= next_bank;
      key_q <= next_key;
      op_q <= next_op;
      cnt <= next_cnt;
      lock_q <= next_lock;
      lock_cap <= next_lock_cap;
      cache <= next_cache;
      cmask <= next_cmask;
      fa <= next_fa;
      fd <= next_fd;
      fm <= next_fm;
      err <= next_err;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // Checks on the sequencer
  property p_stall;
    @(posedge clk_i) disable iff (rst_i)
      (op_q != OP_IDLE) |-> stall_o;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall in op");
  property p_dead;
    @(posedge clk_i) disable iff (rst_i)
      (key_q == KEY_DEAD) |=> (key_q == KEY_DEAD) && (op_q != OP_ERASE || $past(op_q) == OP_ERASE);
  endproperty
  a_dead: assert property (p_dead) else $error("key dead left");
  property p_relock;
    @(posedge clk_i) disable iff (rst_i)
      (op_q == OP_IDLE && $past(op_q) == OP_IDLE ##1 op_q != OP_IDLE) |-> key_q != KEY_OPEN;
  endproperty
  a_relock: assert property (p_relock) else $error("key not relocked");
  property p_supply;
    @(posedge clk_i) disable iff (rst_i)
      (modify && op_q == OP_IDLE && !supmon_en_i) |=> flash_err_rst_o;
  endproperty
  a_supply: assert property (p_supply) else $error("no supply error");
  property p_load;
    @(posedge clk_i) disable iff (rst_i) ld_valid_i |-> ram_re_o;
  endproperty
  a_load: assert property (p_load) else $error("load not to ram");
  property p_short;
    @(posedge clk_i) disable iff (rst_i)
      (st_valid_i && st_short_i && st_addr_i > 16'h00FF) |-> !modify;
  endproperty
  a_short: assert property (p_short) else $error("short store hit flash");
  property p_erase;
    @(posedge clk_i) disable iff (rst_i)
      (op_q == OP_IDLE ##1 op_q == OP_ERASE) |-> fd == 32'hFFFF_FFFF && fa[9:0] == 10'h000;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not page");
  property p_blk;
    @(posedge clk_i) disable iff (rst_i)
      (op_q == OP_IDLE ##1 op_q == OP_WRITE && block_write_enable) |-> $past(st_full[1:0]) == 2'b11;
  endproperty
  a_blk: assert property (p_blk) else $error("block early commit");
  // Protection and interlock checks
  property p_prot;
    @(posedge clk_i) disable iff (rst_i)
      (modify && op_q == OP_IDLE && page_prot) |=> flash_err_rst_o;
  endproperty
  a_prot: assert property (p_prot) else $error("no error on locked store");
  property p_rd_err;
    @(posedge clk_i) disable iff (rst_i)
      (code_rd_i && rd_locked && !dbg_i && !exec_locked_i) |=> flash_err_rst_o;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("no error on locked read");
  property p_dbg;
    @(posedge clk_i) disable iff (rst_i)
      (code_rd_i && dbg_i && rd_locked) |-> !code_rd_ok_o;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug read of locked page");
  // Lock view must not move once captured
  property p_lock_hold;
    @(posedge clk_i) disable iff (rst_i)
      lock_cap |=> $stable(lock_q);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock view changed");
  property p_wmask;
    @(posedge clk_i) disable iff (rst_i)
      (op_q == OP_IDLE ##1 op_q == OP_WRITE && !block_write_enable) |->
        $onehot(fl_mask_o);
  endproperty
  a_wmask: assert property (p_wmask) else $error("byte write not one lane");
  property p_rst_src;
    @(posedge clk_i) disable iff (rst_i)
      (modify && op_q == OP_IDLE && !supmon_rst_en_i) |=> flash_err_rst_o;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("no reset source error");
  property p_erase_en;
    @(posedge clk_i) disable iff (rst_i)
      (op_q == OP_IDLE ##1 op_q == OP_ERASE) |->
        $past(store_erase_enable) && $past(store_write_enable);
  endproperty
  a_erase_en: assert property (p_erase_en) else $error("erase not enabled");
  property p_blk_mask;
    @(posedge clk_i) disable iff (rst_i)
      (op_q == OP_IDLE ##1 op_q == OP_WRITE && block_write_enable) |->
        fl_mask_o[3];
  endproperty
  a_blk_mask: assert property (p_blk_mask) else $error("block without top lane");
  // Flash-bound stores never reach RAM
  property p_no_ram;
    @(posedge clk_i) disable iff (rst_i)
      modify |-> !ram_we_o;
  endproperty
  a_no_ram: assert property (p_no_ram) else $error("flash store hit ram");
  property p_keep_we;
    @(posedge clk_i) disable iff (rst_i)
      (store_write_enable &&
        !(wb_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])) |=>
        store_write_enable;
  endproperty
  a_keep_we: assert property (p_keep_we) else $error("write enable dropped");
  c_block: cover property (@(posedge clk_i) fl_we_o && fl_mask_o == 4'hF);
  c_dbg: cover property (@(posedge clk_i) code_rd_i && dbg_i && rd_locked);
  c_erase: cover property (@(posedge clk_i) op_q == OP_ERASE);
  c_write: cover property (@(posedge clk_i) op_q == OP_WRITE);
  c_dead: cover property (@(posedge clk_i) key_q == KEY_DEAD);
endmodule : flash_program_erase_lock
`default_nettype wire

// [flash_program_erase_lock_bench.sv]
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module flash_program_erase_lock_bench;
  import flash_seq_pkg::*;
  localparam int WR = 8;
  localparam int ER = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, go = 1'b0, sh = 1'b0;
  logic [3:0] adr = 4'h0, fm, fm_c;
  logic [31:0] dw = 32'h0, dr, fd, fd_c, q;
  logic [15:0] sa = 16'h0, st_a;
  logic [7:0] sd = 8'h00, st_d, lb = 8'hFF;
  logic [16:0] ca = 17'h0, fa, fa_c;
  logic st_v, st_s, ram_we, ram_re, stall, ok, fwe, fer, err, cause;
  logic ld = 1'b0, crd = 1'b0, dbg = 1'b0, sm_en = 1'b1;
  logic sm_rst = 1'b1, xl = 1'b0;
  logic s_we, s_er, s_err, s_ram;
  int n_tests = 0, n_mismatch = 0, n_st;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  flash_program_erase_lock #(.WRITE_CYCLES(WR), .ERASE_CYCLES(ER))
    u_flash_program_erase_lock (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .st_valid_i(st_v), .st_short_i(st_s), .st_addr_i(st_a),
    .st_data_i(st_d), .ld_valid_i(ld), .exec_locked_i(xl),
    .ram_we_o(ram_we), .ram_re_o(ram_re), .stall_o(stall),
    .code_rd_i(crd), .dbg_i(dbg), .code_addr_i(ca), .code_rd_ok_o(ok),
    .supmon_en_i(sm_en), .supmon_rst_en_i(sm_rst), .fl_we_o(fwe),
    .fl_erase_o(fer), .fl_addr_o(fa), .fl_data_o(fd), .fl_mask_o(fm),
    .lock_byte_i(lb), .flash_err_rst_o(err),
    .flash_error_cause_flag(cause));
  core_model u_core_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .short_i(sh), .addr_i(sa), .data_i(sd), .stall_i(stall),
    .st_valid_o(st_v), .st_short_o(st_s), .st_addr_o(st_a),
    .st_data_o(st_d));
  // Reset, then three idle edges before any request
  task do_reset;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : do_reset
  // Classic single cycle; held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHK("ack", 1'b1, ack)
  endtask : wb
  task keys;
    wb(1'b1, REG_KEY, {24'h0, KEY_FIRST});
    wb(1'b1, REG_KEY, {24'h0, KEY_SECOND});
  endtask : keys
  // One store, then watch the flash port for a fixed window
  task sto(input logic [15:0] a, input logic [7:0] d, input logic s);
    @(posedge clk_i);
    go <= 1'b1;
    sa <= a;
    sd <= d;
    sh <= s;
    @(posedge clk_i);
    go <= 1'b0;
    {s_we, s_er, s_err, s_ram} = 4'h0;
    n_st = 0;
    repeat (40) begin
      @(negedge clk_i);
      s_we |= fwe;
      s_er |= fer;
      s_err |= err;
      s_ram |= ram_we;
      n_st += int'(stall === 1'b1);
      if (fwe === 1'b1 || fer === 1'b1) begin
        fa_c = fa;
        fd_c = fd;
        fm_c = fm;
      end
    end
    @(posedge clk_i);
  endtask : sto
  task t_write;
    wb(1'b1, REG_BANK, 32'h1);
    wb(1'b1, REG_CTRL, 32'h1);
    keys();
    sto(16'h0123, 8'h5A, 1'b0);
    `CHK("addr", 17'h10123, fa_c)
    `CHK("mask", 4'h8, fm_c)
    `CHK("data", 8'h5A, fd_c[31:24])
    `CHK("stall", WR, n_st)
    `CHK("ram", 1'b0, s_ram)
    wb(1'b0, REG_KEY, 32'h0);
    `CHK("relock", KEY_LOCKED, q[1:0])
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK("we bit", 1'b1, q[0])
    wb(1'b1, REG_BANK, 32'h0);
  endtask : t_write
  task t_erase;
    ld <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h2);
    `CHK("load", 1'b1, ram_re)
    sto(16'h0456, 8'h00, 1'b0);
    `CHK("no erase", 1'b0, s_er)
    `CHK("to ram", 1'b1, s_ram)
    wb(1'b1, REG_CTRL, 32'h3);
    keys();
    sto(16'h0456, 8'h00, 1'b0);
    `CHK("erase", 1'b1, s_er)
    `CHK("page", 17'h00400, fa_c)
    `CHK("emask", 4'hF, fm_c)
    `CHK("etime", ER, n_st)
  endtask : t_erase
  task t_block;
    wb(1'b1, REG_CTRL, 32'h5);
    for (int i = 0; i < 4; i++) begin
      keys();
      sto(16'h0200 + 16'(i), 8'hC0 + 8'(i), 1'b0);
      `CHK("blk we", (i == 3), s_we)
    end
    `CHK("blk data", 32'hC3C2C1C0, fd_c)
    `CHK("blk mask", 4'hF, fm_c)
    `CHK("blk time", WR, n_st)
    keys();
    sto(16'h0204, 8'h11, 1'b0);
    `CHK("cached", 1'b0, s_we)
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, REG_CTRL, 32'h5);
    keys();
    sto(16'h0207, 8'h33, 1'b0);
    `CHK("dropped", 4'h8, fm_c)
  endtask : t_block
  task t_guard;
    keys();
    sto(16'h0123, 8'h00, 1'b1);
    `CHK("short", 1'b0, s_we)
    do_reset();
    sm_en <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h1);
    keys();
    sto(16'h0010, 8'h00, 1'b0);
    `CHK("supply", 1'b1, s_err)
    sm_en <= 1'b1;
    sm_rst <= 1'b0;
    sto(16'h0010, 8'h00, 1'b0);
    `CHK("reset src", 1'b1, s_err)
    sm_rst <= 1'b1;
  endtask : t_guard
  task t_dead;
    for (int i = 0; i < 3; i++) begin
      do_reset();
      wb(1'b1, REG_CTRL, 32'h1);
      if (i < 2) wb(1'b1, REG_KEY, (i == 1) ? 32'hF1 : 32'h11);
      else sto(16'h0300, 8'h00, 1'b0);
      wb(1'b0, REG_KEY, 32'h0);
      `CHK("dead", KEY_DEAD, q[1:0])
      keys();
      sto(16'h0300, 8'h00, 1'b0);
      `CHK("dead we", 1'b0, s_we)
    end
  endtask : t_dead
  // Debug reads of locked pages are gated quietly
  task t_lock(input logic [7:0] b, input logic [16:0] a, input logic e);
    lb <= b;
    do_reset();
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("status", b, q[7:0])
    crd <= 1'b1;
    dbg <= 1'b1;
    ca <= a;
    @(negedge clk_i);
    `CHK("gate", e, ok)
    `CHK("quiet", 1'b0, err)
    @(posedge clk_i);
    dbg <= 1'b0;
    xl <= 1'b1;
    @(negedge clk_i);
    `CHK("own read", 1'b1, ok)
    @(posedge clk_i);
    crd <= 1'b0;
    xl <= 1'b0;
  endtask : t_lock
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    do_reset();
    t_write();
    t_erase();
    t_block();
    t_guard();
    t_dead();
    t_lock(8'hFD, 17'h003FF, 1'b0);
    t_lock(8'hFD, 17'h00800, 1'b1);
    t_lock(8'hFD, 17'h1FFFF, 1'b0);
    t_lock(8'h80, 17'h1F000, 1'b0);
    wb(1'b1, REG_CTRL, 32'h1);
    keys();
    sto(16'h0010, 8'h00, 1'b0);
    `CHK("user err", 1'b1, s_err)
    close_out();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end
endmodule : flash_program_erase_lock_bench
`default_nettype wire

// [flash_seq_pkg.sv]
// Constants, types and timing for the flash program and erase sequencer
package flash_seq_pkg;
  localparam int ADDR_W = 17;
  localparam int PAGE_W = 7;
  localparam int PAGE_BITS = 10;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 17'h1FFFF;
  localparam logic [ADDR_W-1:0] SHORT_MAX = 17'h000FF;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  // Wishbone register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_KEY = 4'h4;
  localparam logic [3:0] REG_BANK = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int CTRL_WE = 0;
  localparam int CTRL_EE = 1;
  localparam int CTRL_BLK = 2;
  // Operation times
  localparam int CLK_MHZ = 200;
  localparam int WRITE_US = 60;
  localparam int ERASE_US = 20;
  localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ * 1000;
  localparam int CNT_W = 24;
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b11,
    KEY_DEAD = 2'b10
  } key_state_t;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_WRITE = 2'b01,
    OP_ERASE = 2'b11
  } op_state_t;
endpackage : flash_seq_pkg
